// ==== rtl/ipw_watchdog.v ====
`timescale 1ns/1ps
// Functional notes
// - Index port then data port register access
// - Double unlock key opens configuration
// - Lock key closes configuration
// - Function select picks watchdog registers
// - Activation bit enables; disabled after reset
// - Unit bit 3: seconds or minutes
// - Zero count stops; nonzero sets length
// - Interval one to 255 units
// - Expiry drives interrupt or reset output
// - Count write restarts countdown
// - Control bit 7: mouse reloads timer
// - Control bit 6: keyboard reloads timer
// - Control bit 5 forces timeout while activation bit is set, self-clears
// - Control bit 4 reads timeout status
`include "ipw_defines.vh"

module ipw_watchdog #(
    parameter integer TICK_CYCLES = `IPW_TICK_CYCLES,
    parameter integer PULSE_CYCLES = 16
) (
    input wire sys_clk_in,
    input wire arst_n_in,
    input wire [15:0] io_addr_in,
    input wire [7:0] io_wdata_in,
    input wire io_wr_in,
    input wire io_rd_in,
    input wire mouse_act_in,
    input wire kbd_act_in,
    input wire action_reset_in,
    output reg [7:0] io_rdata_out,
    output wire unlocked_out,
    output wire timeout_output_out,
    output wire timeout_irq_out,
    output wire timeout_rst_n_out
);

    ////////////////////////////////////////////////////////////////////////
    // Configuration access

    reg [7:0] index_q;
    reg key_seen_q;
    reg unlocked_q;
    reg [7:0] func_q;
    reg enable_q;
    reg [7:0] unit_q;
    reg [7:0] reload_q;
    reg [7:0] count_q;
    reg mouse_en_q;
    reg kbd_en_q;
    reg status_q;
    reg [7:0] pulse_q;

    wire idx_wr = io_wr_in && (io_addr_in == `IPW_PORT_INDEX);
    wire dat_wr = io_wr_in && (io_addr_in == `IPW_PORT_DATA);
    wire dat_rd = io_rd_in && (io_addr_in == `IPW_PORT_DATA);
    wire wd_sel = unlocked_q && (func_q == `IPW_FUNC_WATCHDOG);

    function reg_hit;
        input [7:0] idx;
        input [7:0] reg_idx;
        begin
            reg_hit = (idx == reg_idx);
        end
    endfunction

    wire wr_act = dat_wr && wd_sel && reg_hit(index_q, `IPW_REG_ACTIVATE);
    wire wr_unit = dat_wr && wd_sel && reg_hit(index_q, `IPW_REG_UNIT);
    wire wr_cnt = dat_wr && wd_sel && reg_hit(index_q, `IPW_REG_COUNT);
    wire wr_ctrl = dat_wr && wd_sel && reg_hit(index_q, `IPW_REG_CTRL);
    wire force_to = wr_ctrl && io_wdata_in[`IPW_CTRL_FORCE_BIT];

    always @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            index_q <= 8'h00;
            key_seen_q <= 1'b0;
            unlocked_q <= 1'b0;
            func_q <= 8'h00;
        end else begin
            if (idx_wr) begin
                if (!unlocked_q) begin
                    // Any other byte between the two keys breaks the pair
                    key_seen_q <= (io_wdata_in == `IPW_KEY_UNLOCK) && !key_seen_q;
                    if (key_seen_q && io_wdata_in == `IPW_KEY_UNLOCK) begin
                        unlocked_q <= 1'b1;
                    end
                end else if (io_wdata_in == `IPW_KEY_LOCK) begin
                    unlocked_q <= 1'b0;
                    key_seen_q <= 1'b0;
                end else begin
                    index_q <= io_wdata_in;
                end
            end
            if (dat_wr && unlocked_q && reg_hit(index_q, `IPW_REG_FUNC_SEL)) begin
                func_q <= io_wdata_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Watchdog registers

    always @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            enable_q <= 1'b0;
            unit_q <= `IPW_RST_UNIT;
            reload_q <= `IPW_RST_COUNT;
            mouse_en_q <= 1'b0;
            kbd_en_q <= 1'b0;
        end else begin
            if (wr_act) begin
                enable_q <= io_wdata_in[`IPW_ACT_EN_BIT];
            end
            if (wr_unit) begin
                unit_q <= io_wdata_in;
            end
            if (wr_cnt) begin
                reload_q <= io_wdata_in;
            end
            if (wr_ctrl) begin
                mouse_en_q <= io_wdata_in[`IPW_CTRL_MOUSE_BIT];
                kbd_en_q <= io_wdata_in[`IPW_CTRL_KBD_BIT];
            end
        end
    end

    always @* begin
        io_rdata_out = 8'h00;
        if (dat_rd && unlocked_q) begin
            case (index_q)
                `IPW_REG_FUNC_SEL: io_rdata_out = func_q;
                `IPW_REG_ACTIVATE: io_rdata_out = wd_sel ? {7'd0, enable_q} : 8'h00;
                `IPW_REG_UNIT: io_rdata_out = wd_sel ? unit_q : 8'h00;
                `IPW_REG_COUNT: io_rdata_out = wd_sel ? count_q : 8'h00;
                `IPW_REG_CTRL: io_rdata_out = wd_sel ?
                    {mouse_en_q, kbd_en_q, 1'b0, status_q, 4'h0} : 8'h00;
                default: io_rdata_out = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Countdown

    wire act_reload = (mouse_en_q && mouse_act_in) || (kbd_en_q && kbd_act_in);
    wire restart = wr_cnt || act_reload;
    wire unit_tick;

    ipw_tick_gen #(
        .TICK_CYCLES(TICK_CYCLES),
        .SEC_PER_MIN(`IPW_SEC_PER_MIN)
    ) u_tick (
        .sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .restart_in(restart),
        .minutes_in(unit_q[`IPW_UNIT_MIN_BIT]),
        .unit_tick_out(unit_tick)
    );

    wire expire = enable_q && unit_tick && (count_q == 8'h01);
    wire fire = enable_q && (expire || force_to);

    always @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            count_q <= `IPW_RST_COUNT;
            status_q <= 1'b0;
            pulse_q <= 8'h00;
        end else begin
            if (wr_cnt) begin
                count_q <= io_wdata_in;
            end else if (act_reload) begin
                count_q <= reload_q;
            end else if (enable_q && unit_tick && count_q != 8'h00) begin
                count_q <= count_q - 8'h01;
            end
            // Set wins over the clear from a count write
            if (fire) begin
                status_q <= 1'b1;
            end else if (wr_cnt) begin
                status_q <= 1'b0;
            end
            if (fire) begin
                pulse_q <= PULSE_CYCLES[7:0];
            end else if (pulse_q != 8'h00) begin
                pulse_q <= pulse_q - 8'h01;
            end
        end
    end

    // Stretched pulse so a slow reset controller sees it
    assign timeout_output_out = (pulse_q != 8'h00);
    assign timeout_irq_out = timeout_output_out && !action_reset_in;
    assign timeout_rst_n_out = !(timeout_output_out && action_reset_in);
    assign unlocked_out = unlocked_q;

endmodule // ipw_watchdog

// ==== rtl/ipw_defines.vh ====
`ifndef IPW_DEFINES_VH
`define IPW_DEFINES_VH

// I/O port addresses of the index/data pair
`define IPW_PORT_INDEX 16'h002E
`define IPW_PORT_DATA 16'h002F

// Keys written to the index port
`define IPW_KEY_UNLOCK 8'h87
`define IPW_KEY_LOCK 8'hAA

// Register indices
`define IPW_REG_FUNC_SEL 8'h07
`define IPW_REG_ACTIVATE 8'h30
`define IPW_REG_UNIT 8'hF0
`define IPW_REG_COUNT 8'hF1
`define IPW_REG_CTRL 8'hF2

// Function number of the watchdog
`define IPW_FUNC_WATCHDOG 8'h08

// Field positions
`define IPW_ACT_EN_BIT 0
`define IPW_UNIT_MIN_BIT 3
`define IPW_CTRL_MOUSE_BIT 7
`define IPW_CTRL_KBD_BIT 6
`define IPW_CTRL_FORCE_BIT 5
`define IPW_CTRL_STAT_BIT 4

// Reset values
`define IPW_RST_COUNT 8'h00
`define IPW_RST_UNIT 8'h00
`define IPW_RST_CTRL 8'h00

// Timing
`define IPW_CLK_HZ 25000000
`define IPW_TICK_PERIOD_S 1
`define IPW_TICK_CYCLES (`IPW_CLK_HZ * `IPW_TICK_PERIOD_S)
`define IPW_SEC_PER_MIN 60

`endif

// ==== rtl/ipw_tick_gen.v ====
`timescale 1ns/1ps
`include "ipw_defines.vh"

module ipw_tick_gen #(
    parameter integer TICK_CYCLES = `IPW_TICK_CYCLES,
    parameter integer SEC_PER_MIN = `IPW_SEC_PER_MIN
) (
    input wire sys_clk_in,
    input wire arst_n_in,
    input wire restart_in,
    input wire minutes_in,
    output wire unit_tick_out
);

    reg [24:0] presc_q;
    reg [5:0] sec_q;
    wire sec_tick;

    // Prescaler restarts with the timer, so the first unit is a full one
    assign sec_tick = (presc_q == TICK_CYCLES[24:0] - 25'd1);
    assign unit_tick_out = minutes_in ?
        (sec_tick && sec_q == SEC_PER_MIN[5:0] - 6'd1) : sec_tick;

    always @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            presc_q <= 25'd0;
            sec_q <= 6'd0;
        end else if (restart_in) begin
            presc_q <= 25'd0;
            sec_q <= 6'd0;
        end else if (sec_tick) begin
            presc_q <= 25'd0;
            if (sec_q == SEC_PER_MIN[5:0] - 6'd1) begin
                sec_q <= 6'd0;
            end else begin
                sec_q <= sec_q + 6'd1;
            end
        end else begin
            presc_q <= presc_q + 25'd1;
        end
    end

endmodule // ipw_tick_gen

// ==== tb/ipw_watchdog_asserts.sv ====
`timescale 1ns/1ps
module ipw_watchdog_asserts (
    input wire sys_clk_in,
    input wire arst_n_in,
    input wire [15:0] io_addr_in,
    input wire [7:0] io_wdata_in,
    input wire io_wr_in,
    input wire io_rd_in,
    input wire action_reset_in,
    input wire [7:0] io_rdata_out,
    input wire unlocked_out,
    input wire timeout_output_out,
    input wire timeout_irq_out,
    input wire timeout_rst_n_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);
    wire idx_wr = io_wr_in && io_addr_in == 16'h002E;
    wire key_on = idx_wr && io_wdata_in == 8'h87;
    wire key_off = idx_wr && io_wdata_in == 8'hAA;
    sequence s_unlock;
        key_on ##1 key_on;
    endsequence
    a_unlock_pair: assert property (s_unlock |=> unlocked_out)
        else $error("double key did not unlock");
    a_unlock_cause: assert property (!unlocked_out && !key_on |=> !unlocked_out)
        else $error("unlocked without key");
    a_lock_key: assert property (unlocked_out && key_off |=> !unlocked_out)
        else $error("lock key ignored");
    a_lock_hold: assert property (unlocked_out && !key_off |=> unlocked_out)
        else $error("locked without key");
    a_locked_read: assert property (!unlocked_out && io_rd_in |-> io_rdata_out == 8'h00)
        else $error("read data while locked");
    a_read_idle: assert property (
        !(io_rd_in && io_addr_in == 16'h002F) |-> io_rdata_out == 8'h00)
        else $error("read data off data port");
    a_irq_route: assert property (
        timeout_irq_out == (timeout_output_out && !action_reset_in))
        else $error("interrupt routing wrong");
    a_rst_route: assert property (
        timeout_rst_n_out == !(timeout_output_out && action_reset_in))
        else $error("reset routing wrong");
    a_pulse_hold: assert property ($rose(timeout_output_out) |-> timeout_output_out [*8])
        else $error("timeout pulse too short");
endmodule // ipw_watchdog_asserts

bind ipw_watchdog ipw_watchdog_asserts u_chk (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .io_addr_in(io_addr_in), .io_wdata_in(io_wdata_in), .io_wr_in(io_wr_in), .io_rd_in(io_rd_in),
    .action_reset_in(action_reset_in), .io_rdata_out(io_rdata_out), .unlocked_out(unlocked_out),
    .timeout_output_out(timeout_output_out), .timeout_irq_out(timeout_irq_out),
    .timeout_rst_n_out(timeout_rst_n_out));

// ==== tb/ipw_watchdog_test.sv ====
`timescale 1ns/1ps
module ipw_watchdog_test;
    localparam int TK = 10;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, ms = 0, kb = 0, ar = 0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wd = 8'h00, v, c;
    wire [7:0] rdata;
    wire unl, tmo, irq, rstn;
    int n_errors = 0, checks_done = 0, n;
    int unsigned rng = 79;
    ipw_watchdog #(.TICK_CYCLES(TK)) u_dut (.sys_clk_in(clk), .arst_n_in(rst_n),
        .io_addr_in(addr), .io_wdata_in(wd), .io_wr_in(wr), .io_rd_in(rd), .mouse_act_in(ms),
        .kbd_act_in(kb), .action_reset_in(ar), .io_rdata_out(rdata), .unlocked_out(unl),
        .timeout_output_out(tmo), .timeout_irq_out(irq), .timeout_rst_n_out(rstn));
    always #20 clk = ~clk;
    ////////////////////////////////////////////////////////////////
    function automatic int unsigned nxt();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic put(input logic dp, input logic [7:0] d);
        @(posedge clk);
        addr <= dp ? 16'h002F : 16'h002E;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic setr(input logic [7:0] i, input logic [7:0] d);
        put(1'b0, i);
        put(1'b1, d);
    endtask
    task automatic getr(input logic [7:0] i);
        put(1'b0, i);
        @(posedge clk);
        addr <= 16'h002F;
        rd <= 1'b1;
        @(negedge clk);
        v = rdata;
        @(posedge clk);
        rd <= 1'b0;
    endtask
    // Tolerance covers the cycle offset between restart and the first counted edge
    task automatic meas(input int exp);
        n = 0;
        while (tmo !== 1'b1 && n < 40000) begin
            @(negedge clk);
            n++;
        end
        chk(8'(n >= exp - 3 && n <= exp + 3), 8'h01);
        chk({7'h00, irq}, {7'h00, !ar});
        chk({7'h00, rstn}, {7'h00, !ar});
        repeat (20) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        setr(8'h07, 8'h08);
        chk({7'h00, unl}, 8'h00);
        put(1'b0, 8'h87);
        put(1'b0, 8'h87);
        @(negedge clk);
        chk({7'h00, unl}, 8'h01);
        getr(8'h07);
        chk(v, 8'h00);
        setr(8'h07, 8'h08);
        for (int i = 0; i < 3; i++) begin
            getr(8'hF0 + 8'(i));
            chk(v, 8'h00);
        end
        setr(8'hF1, 8'h01);
        repeat (40) @(posedge clk);
        chk({7'h00, tmo}, 8'h00);
        setr(8'hF1, 8'h00);
        setr(8'h30, 8'h01);
        repeat (40) @(posedge clk);
        chk({7'h00, tmo}, 8'h00);
        for (int i = 0; i < 4; i++) begin
            c = i == 0 ? 8'h01 : i == 1 ? 8'hFF : 8'(nxt() % 8 + 2);
            ar <= 1'(nxt());
            setr(8'hF1, c);
            meas(c * TK);
            getr(8'hF2);
            chk(v & 8'h10, 8'h10);
            setr(8'hF1, 8'h00);
            getr(8'hF2);
            chk(v & 8'h10, 8'h00);
        end
        setr(8'hF1, 8'h05);
        getr(8'hF1);
        chk(v, 8'h05);
        repeat (30) @(posedge clk);
        setr(8'hF1, 8'h05);
        meas(5 * TK);
        for (int s = 0; s < 4; s++) begin
            getr(8'hF2);
            chk(v & 8'hC0, s == 2 ? 8'h80 : 8'h00);
            setr(8'hF2, (v & 8'h3F) | (s[0] ? (s[1] ? 8'h40 : 8'h80) : 8'h00));
            setr(8'hF1, 8'h04);
            repeat (25) @(posedge clk);
            ms <= !s[1];
            kb <= s[1];
            @(posedge clk);
            ms <= 1'b0;
            kb <= 1'b0;
            @(posedge clk);
            meas(s[0] ? 4 * TK : 4 * TK - 27);
        end
        setr(8'hF0, 8'h08);
        setr(8'hF1, 8'h01);
        meas(60 * TK);
        setr(8'hF0, 8'h00);
        setr(8'hF2, 8'h20);
        meas(0);
        getr(8'hF2);
        chk(v & 8'h30, 8'h10);
        put(1'b0, 8'hAA);
        @(negedge clk);
        chk({7'h00, unl}, 8'h00);
        getr(8'hF2);
        chk(v, 8'h00);
        // Back to back key pair, strobe held over two edges
        @(posedge clk);
        addr <= 16'h002E;
        wd <= 8'h87;
        wr <= 1'b1;
        repeat (2) @(posedge clk);
        wr <= 1'b0;
        @(negedge clk);
        chk({7'h00, unl}, 8'h01);
        wrap_up();
    end
    initial begin
        repeat (30000) @(posedge clk);
        n_errors++;
        wrap_up();
    end
endmodule // ipw_watchdog_test
